// ---- verilog/user_config_consts.vh ----
`ifndef USER_CONFIG_CONSTS_VH
`define USER_CONFIG_CONSTS_VH

// Flash addresses of the two configuration words
`define CFG0_ADDR         32'h0030_0000
`define CFG1_ADDR         32'h0030_0004
// Field positions in the boot and lock word
`define CFG0_DF_DIS_BIT   0
`define CFG0_LOCK_BIT     1
`define CFG0_BOOT_LO_BIT  6
`define CFG0_BOOT_HI_BIT  7
`define CFG0_EVEN_TRI_BIT 8
`define CFG0_ODD_TRI_BIT  9
// Field positions in the data flash base word
`define CFG1_BASE_HI      19
`define CFG1_ALIGN_HI     8
// Bit positions in the pin output-enable control register
`define POEN_EVEN0_BIT    0
`define POEN_ODD0_BIT     1
// Region base addresses when both regions are mapped
`define LOADER_BASE_MAP   32'h0010_0000
`define APP_BASE_MAP      32'h0000_0000
// Top of the remappable vector window
`define VEC_WINDOW_TOP    32'h0000_01FF
// Remap field position in the self-programming status register
`define VECTOR_REMAP_FIELD_LO         9
`define VECTOR_REMAP_FIELD_HI         20
// Value returned to the external programmer for locked data
`define LOCKED_READ_DATA  32'h0FFF_FFFF
// Reset values of the loaded words before the load completes
`define CFG0_RESET        32'hFFFF_FFFF
`define CFG1_RESET        32'h0000_0000

`endif

// ---- verilog/cfg_word_fetch.v ----
`include "user_config_consts.vh"

// Reads one flash word: issues the address, waits, captures the data.
module cfg_word_fetch #(
	parameter READ_WAIT = 2
) (
	input  wire        clk_in,    // System clock
	input  wire        rst_in,    // Asynchronous reset, high
	input  wire        start_in,  // Start pulse
	input  wire [31:0] addr_in,   // Word address to read
	input  wire [31:0] rdata_in,  // Flash read data
	output reg         req_out,   // Flash read request
	output reg  [31:0] addr_out,  // Flash read address
	output reg  [31:0] data_out,  // Captured word
	output reg         done_out   // One-cycle done pulse
);

	reg [7:0] wait_q;

	// Holds the request for READ_WAIT + 1 cycles, then samples the data
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			req_out  <= 1'b0;
			addr_out <= 32'h0000_0000;
			data_out <= 32'h0000_0000;
			done_out <= 1'b0;
			wait_q   <= 8'h00;
		end else begin
			done_out <= 1'b0;
			if (start_in && !req_out) begin
				req_out  <= 1'b1;
				addr_out <= addr_in;
				wait_q   <= READ_WAIT[7:0];
			end else if (req_out) begin
				if (wait_q == 8'h00) begin
					req_out  <= 1'b0;
					data_out <= rdata_in;
					done_out <= 1'b1;
				end else begin
					wait_q <= wait_q - 8'h01;
				end
			end
		end
	end

endmodule

// ---- verilog/user_config_boot_loader.v ----
`include "user_config_consts.vh"

module user_config_boot_loader #(
	parameter IS_128K   = 1,
	parameter READ_WAIT = 2,
	parameter DEVICE_ID = 32'h0000_1234, // Arbitrary identification value
	parameter ID_ADDR   = 32'h0030_0FF0  // Arbitrary identification location
) (
	input  wire        clk_in,            // System clock, 200 MHz
	input  wire        rst_in,            // Asynchronous reset, high
	// Flash read port used by the loader
	output wire        flash_req_out,     // Flash read request
	output wire [31:0] flash_addr_out,    // Flash read address
	input  wire [31:0] flash_rdata_in,    // Flash read data
	// Processor hold-off
	output reg         cpu_hold_out,      // Holds processor until loaded
	// Pin control
	input  wire        pwm_poen_we_in,    // Software write to enable reg
	input  wire [1:0]  pwm_poen_wdata_in, // Data for unit0 bits
	output reg  [1:0]  pwm_poen_out,      // Unit0 tri-state control bits
	input  wire [1:0]  pin_mode_oe_in,    // Pin-mode driven enables, even/odd
	output reg  [1:0]  pin_drive_oe_out,  // Final pin enables, even/odd
	// Boot mapping
	output reg         boot_app_out,      // Boot from application region
	output reg         iap_map_out,       // Both regions mapped
	output reg  [31:0] loader_base_out,   // Loader region base
	output reg  [31:0] app_base_out,      // Application region base
	input  wire        runtime_bs_in,     // Runtime boot select bit
	output reg         fetch_loader_out,  // Current fetch region is loader
	input  wire [31:0] vecstat_in,        // Self-program status register
	input  wire [31:0] cpu_addr_in,       // Processor fetch address
	output reg  [31:0] cpu_addr_out,      // Remapped fetch address
	// Lock and data flash
	output reg         locked_out,        // Flash contents locked
	output reg         df_enable_out,     // Data flash enabled
	output reg  [31:0] df_base_out,       // Data flash base address
	// External programmer read path
	input  wire [31:0] ext_addr_in,       // External read address
	input  wire [31:0] ext_raw_in,        // Raw flash data at that address
	output reg  [31:0] ext_rdata_out,     // Data shown to programmer
	// Self-programming read path
	input  wire [31:0] isp_raw_in,        // Raw flash data
	output reg  [31:0] isp_rdata_out,     // Data shown to self-programming
	// Loaded words
	output reg  [31:0] cfg0_out,          // Loaded boot and lock word
	output reg  [31:0] cfg1_out           // Loaded data flash base word
);

	// Load walk with READ_WAIT = W: the start pulse comes one edge after
	// release, the request the edge after, the capture W + 1 edges later,
	// then the second word the same way. The processor stays held for the
	// whole walk, but the pin drive, lock and external read logic still decode
	// the all-ones reset pattern of the boot word as a real setting until then.
	// A reset in mid-load simply restarts the walk from the first word.
	localparam ST_FETCH0 = 4'b0001;
	localparam ST_WAIT0  = 4'b0010;
	localparam ST_WAIT1  = 4'b0100;
	localparam ST_DONE   = 4'b1000;

	reg  [3:0]  state_q;
	reg         start_q;
	reg  [31:0] addr_q;
	wire        fetch_done;
	wire [31:0] fetch_data;

	wire        iap_en  = map_enabled(cfg0_out);
	wire [11:0] vec_map = vecstat_in[`VECTOR_REMAP_FIELD_HI:`VECTOR_REMAP_FIELD_LO];

	// Mapping is on while the low boot bit is clear
	function map_enabled;
		input [31:0] word;
		begin
			map_enabled = ~word[`CFG0_BOOT_LO_BIT];
		end
	endfunction

	// Enable-register image of the two unit0 tri-state bits
	function [1:0] poen_from_cfg;
		input [31:0] word;
		begin
			poen_from_cfg = 2'b00;
			poen_from_cfg[`POEN_ODD0_BIT]  = word[`CFG0_ODD_TRI_BIT];
			poen_from_cfg[`POEN_EVEN0_BIT] = word[`CFG0_EVEN_TRI_BIT];
		end
	endfunction

	// True for the two addresses whose raw data an external programmer may always read
	function is_cfg_word;
		input [31:0] addr;
		begin
			is_cfg_word = (addr == `CFG0_ADDR) ||
				(addr == `CFG1_ADDR);
		end
	endfunction

	// True inside the low vector window that the remap field covers
	function in_vec_window;
		input [31:0] addr;
		begin
			in_vec_window = (addr <= `VEC_WINDOW_TOP);
		end
	endfunction

	// Window address moved into the block chosen by the remap field
	function [31:0] vec_remap;
		input [11:0] page;
		input [31:0] addr;
		begin
			vec_remap = {11'h000, page, addr[`VECTOR_REMAP_FIELD_LO-1:0]};
		end
	endfunction

	// Data flash base from the second word; reserved bits read zero
	function [31:0] df_base_of;
		input [31:0] word;
		begin
			df_base_of = {12'h000, word[`CFG1_BASE_HI:0]};
		end
	endfunction

	// Word reader; one fetch engine serves both words in turn

	cfg_word_fetch #(
		.READ_WAIT(READ_WAIT)
	) u_fetch (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.start_in (start_q),
		.addr_in  (addr_q),
		.rdata_in (flash_rdata_in),
		.req_out  (flash_req_out),
		.addr_out (flash_addr_out),
		.data_out (fetch_data),
		.done_out (fetch_done)
	);

	// Loader sequence; words stay fixed until the next reset
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q      <= ST_FETCH0;
			start_q      <= 1'b0;
			addr_q       <= `CFG0_ADDR;
			cfg0_out     <= `CFG0_RESET;
			cfg1_out     <= `CFG1_RESET;
			cpu_hold_out <= 1'b1;
		end else begin
			start_q <= 1'b0;
			case (state_q)
				ST_FETCH0: begin
					start_q <= 1'b1;
					addr_q  <= `CFG0_ADDR;
					state_q <= ST_WAIT0;
				end
				ST_WAIT0: begin
					if (fetch_done) begin
						cfg0_out <= fetch_data;
						start_q  <= 1'b1;
						addr_q   <= `CFG1_ADDR;
						state_q  <= ST_WAIT1;
					end
				end
				ST_WAIT1: begin
					if (fetch_done) begin
						cfg1_out     <= fetch_data;
						cpu_hold_out <= 1'b0;
						state_q      <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_q <= ST_DONE;
				end
				default: begin
					state_q <= ST_FETCH0;
				end
			endcase
		end
	end

	// Tri-state bits: loaded at end of reset load, then software owned.
	// Writes during the load are dropped, so software cannot race the
	// copy and leave the pins driven against the stored setting.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pwm_poen_out <= 2'b00;
		end else if (state_q == ST_WAIT1 && fetch_done) begin
			pwm_poen_out <= poen_from_cfg(cfg0_out);
		end else if (pwm_poen_we_in && !cpu_hold_out) begin
			pwm_poen_out <= pwm_poen_wdata_in;
		end
	end

	// Pin drive: forced tri-state overrides the pin mode registers
	always @* begin
		pin_drive_oe_out = pin_mode_oe_in;
		if (cfg0_out[`CFG0_EVEN_TRI_BIT])
			pin_drive_oe_out[`POEN_EVEN0_BIT] = 1'b0;
		if (cfg0_out[`CFG0_ODD_TRI_BIT])
			pin_drive_oe_out[`POEN_ODD0_BIT] = 1'b0;
	end

	// Boot region and mapping mode straight from the boot field
	always @* begin
		boot_app_out = cfg0_out[`CFG0_BOOT_HI_BIT];
		iap_map_out  = iap_en;
	end

	// Region bases; without mapping only one region shows, at zero
	always @* begin
		loader_base_out = `APP_BASE_MAP;
		app_base_out    = `APP_BASE_MAP;
		if (iap_en) begin
			loader_base_out = `LOADER_BASE_MAP;
			app_base_out    = `APP_BASE_MAP;
		end
	end

	// Fetch region; runtime select ignored while both are mapped,
	// since a switch there would pull code out from under a caller
	always @* begin
		if (iap_en)
			fetch_loader_out = ~boot_app_out;
		else
			fetch_loader_out = runtime_bs_in;
	end

	// Vector remap only with mapping on; otherwise addresses pass as is
	always @* begin
		cpu_addr_out = cpu_addr_in;
		if (iap_en && in_vec_window(cpu_addr_in))
			cpu_addr_out = vec_remap(vec_map, cpu_addr_in);
	end

	// Lock level: a cleared lock bit means locked
	always @* begin
		locked_out = ~cfg0_out[`CFG0_LOCK_BIT];
	end

	// Data flash enable exists only on the larger flash variant
	always @* begin
		df_enable_out = 1'b0;
		if (IS_128K != 0)
			df_enable_out = ~cfg0_out[`CFG0_DF_DIS_BIT];
	end

	// Data flash base; low-bit alignment is left to whoever programs
	// the word, the loader does not mask those bits
	always @* begin
		df_base_out = 32'h0000_0000;
		if (IS_128K != 0)
			df_base_out = df_base_of(cfg1_out);
	end

	// Self-programming reads see real data whatever the lock says
	always @* begin
		isp_rdata_out = isp_raw_in;
	end

	// External reads: identification and both words stay readable
	always @* begin
		if (ext_addr_in == ID_ADDR)
			ext_rdata_out = DEVICE_ID;
		else if (!locked_out || is_cfg_word(ext_addr_in))
			ext_rdata_out = ext_raw_in;
		else
			ext_rdata_out = `LOCKED_READ_DATA;
	end

endmodule

// ---- tb/cfg_flash_model.sv ----
// Flash array holding the two user words, one-cycle read
module cfg_flash_model (
	input  logic        clk_in,    // System clock
	input  logic        req_in,    // Loader read request
	input  logic [31:0] addr_in,   // Read address
	input  logic [31:0] word0_in,  // Stored boot and lock word
	input  logic [31:0] word1_in,  // Stored data flash base word
	output logic [31:0] rdata_out  // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rdata_out = 32'h5A5A_5A5A;
	// Idle bus toggles so a stale sample cannot pass
	always @(posedge clk_in) begin
		if (req_in && addr_in == 32'h0030_0000)
			rdata_out <= word0_in;
		else if (req_in && addr_in == 32'h0030_0004)
			rdata_out <= word1_in;
		else
			rdata_out <= ~rdata_out;
	end
endmodule

// ---- tb/cfg_boot_checker.sv ----
module cfg_boot_checker (
	input logic        clk_in, rst_in, cpu_hold_out, boot_app_out,
	input logic        iap_map_out, locked_out, df_enable_out,
	input logic [1:0]  pwm_poen_out, pin_mode_oe_in, pin_drive_oe_out,
	input logic [31:0] cfg0_out, cfg1_out, loader_base_out, app_base_out,
	input logic [31:0] cpu_addr_in, cpu_addr_out, vecstat_in, df_base_out,
	input logic [31:0] ext_addr_in, ext_raw_in, ext_rdata_out,
	input logic [31:0] isp_raw_in, isp_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Tri-state bits land in the enable register with the load
	chk_odd_copy: assert property ($fell(cpu_hold_out) |->
		pwm_poen_out[1] == cfg0_out[9]) else $error("odd bit not loaded");
	chk_even_copy: assert property ($fell(cpu_hold_out) |->
		pwm_poen_out[0] == cfg0_out[8]) else $error("even bit not loaded");
	chk_even_drive: assert property (pin_drive_oe_out[0] ==
		(pin_mode_oe_in[0] && !cfg0_out[8])) else $error("even drive wrong");
	chk_boot_decode: assert property (boot_app_out == cfg0_out[7] &&
		iap_map_out == !cfg0_out[6]) else $error("boot decode wrong");
	chk_map_bases: assert property (iap_map_out |->
		loader_base_out == 32'h0010_0000 && app_base_out == 32'h0000_0000)
		else $error("mapped bases wrong");
	chk_vector_remap: assert property (iap_map_out &&
		cpu_addr_in <= 32'h0000_01FF |-> cpu_addr_out ==
		{11'h000, vecstat_in[20:9], cpu_addr_in[8:0]}) else $error("remap");
	chk_lock_open: assert property (locked_out && (ext_addr_in ==
		32'h0030_0000 || ext_addr_in == 32'h0030_0004) |->
		ext_rdata_out == ext_raw_in) else $error("config read hidden");
	chk_isp_read: assert property (isp_rdata_out == isp_raw_in)
		else $error("self-program read altered");
	chk_df_base: assert property (df_enable_out |-> df_base_out ==
		{12'h000, cfg1_out[19:0]}) else $error("data flash base wrong");
	// A hung loader would keep the processor held forever
	chk_load_bound: assert property ($fell(rst_in) |->
		##[1:40] !cpu_hold_out) else $error("load did not finish");
	chk_words_hold: assert property (!cpu_hold_out &&
		!$past(cpu_hold_out) |-> $stable(cfg0_out) && $stable(cfg1_out))
		else $error("loaded word changed");
endmodule

bind user_config_boot_loader cfg_boot_checker chk_inst (.*);

// ---- tb/tb_user_config_boot_loader.sv ----
module tb_user_config_boot_loader;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, rst_in, flash_req_out, cpu_hold_out, pwm_poen_we_in;
	logic        boot_app_out, iap_map_out, runtime_bs_in, fetch_loader_out;
	logic        locked_out, df_enable_out;
	logic [1:0]  pwm_poen_wdata_in, pwm_poen_out, pin_mode_oe_in;
	logic [1:0]  pin_drive_oe_out;
	logic [31:0] flash_addr_out, flash_rdata_in, loader_base_out, app_base_out;
	logic [31:0] vecstat_in, cpu_addr_in, cpu_addr_out, df_base_out, w0, w1;
	logic [31:0] ext_addr_in, ext_raw_in, ext_rdata_out, isp_raw_in;
	logic [31:0] isp_rdata_out, cfg0_out, cfg1_out;
	int          bad_count, compares;

	user_config_boot_loader user_config_boot_loader_inst (.*);
	cfg_flash_model cfg_flash_model_inst (.clk_in(clk_in),
		.req_in(flash_req_out), .addr_in(flash_addr_out), .word0_in(w0),
		.word1_in(w1), .rdata_out(flash_rdata_in));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic cmp(input string what, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Reset with new flash words, then wait for the loader to let go
	task automatic boot(input logic [31:0] c0, input logic [31:0] c1);
		int n = 0;
		w0 <= c0;
		w1 <= c1;
		rst_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		do begin
			@(posedge clk_in);
			#1 n++;
		end while (cpu_hold_out !== 1'b0 && n < 100);
		cmp("hold", 0, cpu_hold_out);
	endtask

	initial begin
		#20000 bad_count++;
		close_out;
	end

	initial begin
		rst_in = 1'b1;
		{runtime_bs_in, pwm_poen_we_in, pwm_poen_wdata_in} = 4'h0;
		pin_mode_oe_in = 2'b11;
		vecstat_in = 32'h000A_A000;
		cpu_addr_in = 32'h0000_01FF;
		{ext_addr_in, ext_raw_in} = {32'h0000_0100, 32'h1234_5678};
		isp_raw_in = 32'h8765_4321;
		{w0, w1, bad_count, compares} = 0;
		for (int i = 0; i < 4; i++) begin
			logic [1:0]  b;
			logic [31:0] c0, c1;
			b  = i[1:0];
			c0 = 32'hFFFF_FC00 | (i << 8) | (i << 6) | i;
			c1 = 32'hFFF0_0000 | ((i + 1) << 12);
			@(posedge clk_in);
			ext_addr_in <= b[0] ? 32'h0030_0000 : 32'h0000_0100;
			boot(c0, c1);
			cmp("cfg0", c0, cfg0_out);
			cmp("cfg1", c1, cfg1_out);
			cmp("odd enable", b[1], pwm_poen_out[1]);
			cmp("even enable", b[0], pwm_poen_out[0]);
			cmp("even drive", !b[0], pin_drive_oe_out[0]);
			cmp("boot region", b[1], boot_app_out);
			cmp("mapping", !b[0], iap_map_out);
			cmp("lock", !b[1], locked_out);
			cmp("ext read", b != 0 ? ext_raw_in : 32'h0FFF_FFFF,
				ext_rdata_out);
			cmp("isp read", isp_raw_in, isp_rdata_out);
			cmp("df enable", !b[0], df_enable_out);
			if (!b[0]) begin
				cmp("loader base", 32'h0010_0000, loader_base_out);
				cmp("app base", 0, app_base_out);
				cmp("vector remap", 32'h000A_A1FF, cpu_addr_out);
				cmp("df base", (i + 1) << 12, df_base_out);
				cmp("mapped region", !b[1], fetch_loader_out);
			end else begin
				// Region follows the runtime select only without mapping
				for (int k = 0; k < 2; k++) begin
					@(posedge clk_in);
					runtime_bs_in <= !k;
					#1 cmp("fetch region", !k, fetch_loader_out);
				end
			end
			$display("test boot code %0d done", i);
		end
		// Software owns the enable bits once loading is over
		@(posedge clk_in);
		pwm_poen_we_in    <= 1'b1;
		pwm_poen_wdata_in <= 2'b01;
		@(posedge clk_in);
		pwm_poen_we_in <= 1'b0;
		#1 cmp("poen write", 2'b01, pwm_poen_out);
		// Flash changes after load must not reach the latched words
		@(posedge clk_in);
		w0 <= 32'h0000_0000;
		repeat (5) @(posedge clk_in);
		#1 cmp("cfg0 held", 32'hFFFF_FFC3, cfg0_out);
		$display("test word hold done");
		close_out;
	end
endmodule
